// >>> hw/e1_status_map.svh
// register offsets, field positions and timing counts of the e1 receive status group
// assumes a 125 MHz clock and byte-wide registers on a 5-bit address
`ifndef E1_STATUS_MAP_SVH
`define E1_STATUS_MAP_SVH
`define REG_ALIGN_CAPTURE     5'h15
`define REG_LINE_LEVEL        5'h16
`define REG_JITTER_STATUS     5'h17
`define REG_NONALIGN_CAPTURE  5'h18
`define ALIGN_PATTERN         7'h1b
`define LEVEL_CODE_LSB        3
`define LEVEL_LOS_BIT         2
`define JIT_SLOW_BIT          7
`define JIT_FAST_BIT          6
`define JIT_EMPTY_BIT         5
`define JIT_FOUR_USED_BIT     4
`define JIT_HALF_BIT          3
`define JIT_FOUR_FREE_BIT     2
`define JIT_FULL_BIT          1
`define JIT_NEAR_COUNT        4
`define LOS_TIME_US           1000
`define CLK_MHZ               125
`define LOS_CYCLES            (`LOS_TIME_US * `CLK_MHZ)
`define CAPTURE_RESET         8'h00
`endif

// >>> hw/e1_status_pkg.sv
// types shared by the e1 receive status group
// does not include the map header; widths and level codes are written here as literals
package e1_status_pkg;
  typedef struct packed {
    logic       bit1;      // position one of the word
    logic [6:0] rest;      // positions two to eight
  } rx_word_t;
  typedef enum logic [4:0] {
    lvl_under4 = 5'h01,
    lvl_3to8   = 5'h02,
    lvl_8to14  = 5'h04,
    lvl_14to20 = 5'h08,
    lvl_over20 = 5'h10
  } peak_level_code_t;
  typedef enum logic [1:0] {
    rate_normal,
    rate_slow,
    rate_fast
  } dejitter_rate_t;
endpackage

// >>> hw/rx_word_capture.sv
// one capture register for a received timeslot-zero word
// assumes the strobe and the word come from logic on the same clock
`timescale 1ns/1ns
`include "e1_status_map.svh"
module rx_word_capture
  import e1_status_pkg::*;
(
  input  wire logic     clk,     // system clock
  input  wire logic     resetn,  // async reset, active low
  input  wire logic     load,    // one-cycle strobe, word valid
  input  wire rx_word_t word,    // received word
  output rx_word_t      held_q   // last captured word
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held_q <= `CAPTURE_RESET;
    end else if (load) begin
      held_q <= word;
    end
  end
endmodule

// >>> hw/e1_receive_overhead_status.sv
// e1 receive overhead status: four read-only registers for the host
// assumes frame strobes, level code and fifo state come from logic on clk;
// the analog loss comparator and the register address/strobe pins are asynchronous
//
// Notes on behaviour
// R1: align register bit 7 holds word position one
// R2: bits 6-0 hold alignment positions two to eight
// R3: one-hot peak level code in bits 7-3
// R4: loss flag after 1 ms below threshold
// R5: jitter bit 7 set while clock lengthened
// R6: jitter bit 6 set while clock shortened
// R7: jitter bit 5 set when fifo empty
// R8: jitter bit 4 set at four used or more
// R9: jitter bit 3 set at half full
// R10: jitter bit 2 set at four free or fewer
// R11: jitter bit 1 set when fifo full
// R12: nonalign register bit 7 holds position one
// R13: nonalign bit 6 holds marker, expected one
// R14: nonalign bit 5 holds remote alarm bit
// R15: nonalign bits 4-0 hold national bits
// R16: capture registers refresh on each matching frame
// R17: registers read-only, unused bits read zero
`timescale 1ns/1ns
`include "e1_status_map.svh"
module e1_receive_overhead_status
  import e1_status_pkg::*;
#(
  parameter int          FIFO_DEPTH = 32,             // jitter fifo locations
  parameter int          AW         = 6,              // fifo fill count width
  parameter int unsigned LOS_CYCLES = `LOS_CYCLES     // loss persistence in clocks
) (
  input  wire logic             clk,             // 125 MHz clock
  input  wire logic             resetn,          // async reset, active low
  input  wire logic             align_strobe,    // alignment frame received
  input  wire logic             nonalign_strobe, // non-alignment frame received
  input  wire rx_word_t         ts0_word,        // timeslot-zero word of that frame
  input  wire peak_level_code_t peak_level_code, // peak detector result
  input  wire logic             below_threshold, // comparator level, async
  input  wire dejitter_rate_t   dejitter_rate,   // current output clock adjust
  input  wire logic [AW-1:0]    fifo_fill,       // fifo occupied locations
  input  wire logic [4:0]       reg_addr,        // register address pins
  input  wire logic             rd_n,            // read strobe, active low
  input  wire logic             cs_n,            // chip select, active low
  output logic [7:0]            rd_data_q,       // read data
  output logic                  rd_valid_q       // read data valid level
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  // strobes are synchronised one by one; gating them first could glitch
  logic [1:0] los_sync_q;
  logic [1:0] rd_n_sync_q;
  logic [1:0] cs_n_sync_q;
  logic [4:0] addr_meta_q;
  logic [4:0] addr_sync_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      los_sync_q  <= 2'h0;
      rd_n_sync_q <= 2'h3;
      cs_n_sync_q <= 2'h3;
      addr_meta_q <= 5'h00;
      addr_sync_q <= 5'h00;
    end else begin
      los_sync_q  <= {los_sync_q[0], below_threshold};
      rd_n_sync_q <= {rd_n_sync_q[0], rd_n};
      cs_n_sync_q <= {cs_n_sync_q[0], cs_n};
      addr_meta_q <= reg_addr;
      addr_sync_q <= addr_meta_q;
    end
  end

  wire logic los_level = los_sync_q[1];
  wire logic rd_level  = ~(rd_n_sync_q[1] | cs_n_sync_q[1]);

  // ---------------------------------------------------------------------------
  // frame word captures
  // ---------------------------------------------------------------------------
  rx_word_t align_q;
  rx_word_t nonalign_q;

  rx_word_capture u_align_cap (           // R1 R2 R16
    .clk    (clk),
    .resetn (resetn),
    .load   (align_strobe),
    .word   (ts0_word),
    .held_q (align_q)
  );

  rx_word_capture u_nonalign_cap (        // R12 R13 R14 R15 R16
    .clk    (clk),
    .resetn (resetn),
    .load   (nonalign_strobe),
    .word   (ts0_word),
    .held_q (nonalign_q)
  );

  // ---------------------------------------------------------------------------
  // line loss persistence
  // ---------------------------------------------------------------------------
  logic [31:0] los_cnt_q;
  logic        los_flag_q;

  // counter saturates, so a long outage cannot wrap and drop the flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      los_cnt_q <= 32'h0;
    end else if (!los_level) begin
      los_cnt_q <= 32'h0;
    end else if (los_cnt_q < LOS_CYCLES) begin
      los_cnt_q <= los_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      los_flag_q <= 1'b0;
    end else begin
      los_flag_q <= los_level && (los_cnt_q >= LOS_CYCLES - 1); // R4
    end
  end

  // ---------------------------------------------------------------------------
  // level and jitter status bytes
  // ---------------------------------------------------------------------------
  logic [7:0] level_q;
  logic [7:0] jitter_q;

  function automatic logic [7:0] jitter_byte(input dejitter_rate_t rate,
                                             input logic [AW-1:0] fill);
    logic [7:0] b;
    b = 8'h00;
    b[`JIT_SLOW_BIT]      = (rate == rate_slow);                          // R5
    b[`JIT_FAST_BIT]      = (rate == rate_fast);                          // R6
    b[`JIT_EMPTY_BIT]     = (fill == '0);                                 // R7
    b[`JIT_FOUR_USED_BIT] = (int'(fill) >= `JIT_NEAR_COUNT);              // R8
    b[`JIT_HALF_BIT]      = (int'(fill) * 2 >= FIFO_DEPTH);               // R9
    b[`JIT_FOUR_FREE_BIT] = (FIFO_DEPTH - int'(fill) <= `JIT_NEAR_COUNT); // R10
    b[`JIT_FULL_BIT]      = (int'(fill) >= FIFO_DEPTH);                   // R11
    return b;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= 8'h00;
    end else begin
      level_q <= {peak_level_code, los_flag_q, 2'h0}; // R3 R17
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      jitter_q <= 8'h00;
    end else begin
      jitter_q <= jitter_byte(dejitter_rate, fifo_fill);
    end
  end

  // ---------------------------------------------------------------------------
  // host read port
  // ---------------------------------------------------------------------------
  // no write path exists at all, so host writes cannot disturb any register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_level;
      if (rd_level) begin
        unique case (addr_sync_q)
          `REG_ALIGN_CAPTURE:    rd_data_q <= align_q;    // R1 R2
          `REG_LINE_LEVEL:       rd_data_q <= level_q;    // R3 R4
          `REG_JITTER_STATUS:    rd_data_q <= jitter_q;
          `REG_NONALIGN_CAPTURE: rd_data_q <= nonalign_q; // R12 R15
          default:               rd_data_q <= 8'h00;      // R17
        endcase
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  rx_word_t last_align;
  rx_word_t last_nonalign;
  assign last_align    = align_q;
  assign last_nonalign = nonalign_q;

  property p_align_capture;
    @(posedge clk) disable iff (!resetn)
    align_strobe |=> (align_q == $past(ts0_word));
  endproperty
  a_align_capture: assert property (p_align_capture) else $error("align capture stale"); // R16

  property p_align_read;
    @(posedge clk) disable iff (!resetn)
    (rd_level && addr_sync_q == `REG_ALIGN_CAPTURE) |=> (rd_data_q == $past(last_align));
  endproperty
  a_align_read: assert property (p_align_read) else $error("align read wrong"); // R1

  property p_nonalign_read;
    @(posedge clk) disable iff (!resetn)
    (rd_level && addr_sync_q == `REG_NONALIGN_CAPTURE)
      |=> (rd_data_q[4:0] == $past(last_nonalign.rest[4:0]));
  endproperty
  a_nonalign_read: assert property (p_nonalign_read) else $error("national bits wrong"); // R15

  property p_nonalign_hold;
    @(posedge clk) disable iff (!resetn)
    !nonalign_strobe |=> $stable(nonalign_q);
  endproperty
  a_nonalign_hold: assert property (p_nonalign_hold) else $error("nonalign changed"); // R16

  property p_los_rise;
    @(posedge clk) disable iff (!resetn)
    $rose(los_flag_q) |-> (los_cnt_q >= LOS_CYCLES) && $past(los_level);
  endproperty
  a_los_rise: assert property (p_los_rise) else $error("loss flag early"); // R4

  property p_los_clear;
    @(posedge clk) disable iff (!resetn)
    !los_level |=> !los_flag_q;
  endproperty
  a_los_clear: assert property (p_los_clear) else $error("loss flag held"); // R4

  property p_level_unused;
    @(posedge clk) disable iff (!resetn)
    level_q[1:0] == 2'h0 && jitter_q[0] == 1'b0;
  endproperty
  a_level_unused: assert property (p_level_unused) else $error("unused bits set"); // R17

  property p_empty_full;
    @(posedge clk) disable iff (!resetn)
    (fifo_fill == '0) |=> jitter_q[`JIT_EMPTY_BIT] && !jitter_q[`JIT_FULL_BIT]
                          && !jitter_q[`JIT_FOUR_USED_BIT];
  endproperty
  a_empty_full: assert property (p_empty_full) else $error("empty status wrong"); // R7

  property p_full;
    @(posedge clk) disable iff (!resetn)
    (int'(fifo_fill) == FIFO_DEPTH) |=> jitter_q[`JIT_FULL_BIT]
                                  && jitter_q[`JIT_FOUR_FREE_BIT] && jitter_q[`JIT_HALF_BIT];
  endproperty
  a_full: assert property (p_full) else $error("full status wrong"); // R11

  property p_slow_fast;
    @(posedge clk) disable iff (!resetn)
    (dejitter_rate == rate_slow) |=> jitter_q[`JIT_SLOW_BIT] && !jitter_q[`JIT_FAST_BIT];
  endproperty
  a_slow_fast: assert property (p_slow_fast) else $error("rate status wrong"); // R5

  property p_fast;
    @(posedge clk) disable iff (!resetn)
    (dejitter_rate == rate_fast) |=> jitter_q[`JIT_FAST_BIT] && !jitter_q[`JIT_SLOW_BIT];
  endproperty
  a_fast: assert property (p_fast) else $error("fast status wrong"); // R6

  property p_nonalign_capture;
    @(posedge clk) disable iff (!resetn)
    nonalign_strobe |=> (nonalign_q == $past(ts0_word));
  endproperty
  a_nonalign_capture: assert property (p_nonalign_capture) else $error("nonalign stale"); // R16

  property p_align_hold;
    @(posedge clk) disable iff (!resetn)
    !align_strobe |=> $stable(align_q);
  endproperty
  a_align_hold: assert property (p_align_hold) else $error("align changed"); // R16

  property p_level_code;
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> (level_q[7:`LEVEL_CODE_LSB] == $past(peak_level_code));
  endproperty
  a_level_code: assert property (p_level_code) else $error("level code wrong"); // R3

  property p_level_los;
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> (level_q[`LEVEL_LOS_BIT] == $past(los_flag_q));
  endproperty
  a_level_los: assert property (p_level_los) else $error("loss bit wrong"); // R4

  property p_four_used;
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> (jitter_q[`JIT_FOUR_USED_BIT] == (int'($past(fifo_fill)) >= `JIT_NEAR_COUNT));
  endproperty
  a_four_used: assert property (p_four_used) else $error("four used wrong"); // R8

  property p_half;
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> (jitter_q[`JIT_HALF_BIT] == (2 * int'($past(fifo_fill)) >= FIFO_DEPTH));
  endproperty
  a_half: assert property (p_half) else $error("half status wrong"); // R9

  property p_four_free;
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> (jitter_q[`JIT_FOUR_FREE_BIT]
              == (int'($past(fifo_fill)) + `JIT_NEAR_COUNT >= FIFO_DEPTH));
  endproperty
  a_four_free: assert property (p_four_free) else $error("four free wrong"); // R10

  property p_not_empty;
    @(posedge clk) disable iff (!resetn)
    (fifo_fill != '0) |=> !jitter_q[`JIT_EMPTY_BIT];
  endproperty
  a_not_empty: assert property (p_not_empty) else $error("empty set wrongly"); // R7

  property p_not_full;
    @(posedge clk) disable iff (!resetn)
    (int'(fifo_fill) < FIFO_DEPTH) |=> !jitter_q[`JIT_FULL_BIT];
  endproperty
  a_not_full: assert property (p_not_full) else $error("full set wrongly"); // R11

  property p_rate_normal;
    @(posedge clk) disable iff (!resetn)
    (dejitter_rate == rate_normal) |=> !jitter_q[`JIT_SLOW_BIT] && !jitter_q[`JIT_FAST_BIT];
  endproperty
  a_rate_normal: assert property (p_rate_normal) else $error("rate bits at normal"); // R6

  property p_nonalign_bit1;
    @(posedge clk) disable iff (!resetn)
    (rd_level && addr_sync_q == `REG_NONALIGN_CAPTURE)
      |=> (rd_data_q[7] == $past(last_nonalign.bit1));
  endproperty
  a_nonalign_bit1: assert property (p_nonalign_bit1) else $error("nonalign bit1 wrong"); // R12

  property p_nonalign_flags;
    @(posedge clk) disable iff (!resetn)
    (rd_level && addr_sync_q == `REG_NONALIGN_CAPTURE)
      |=> (rd_data_q[6:5] == $past(last_nonalign.rest[6:5]));
  endproperty
  a_nonalign_flags: assert property (p_nonalign_flags) else $error("marker or alarm wrong"); // R14

  property p_idle_zero;
    @(posedge clk) disable iff (!resetn)
    !rd_level |=> (rd_data_q == 8'h00) && !rd_valid_q;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data outside read"); // R17

  property p_unmapped;
    @(posedge clk) disable iff (!resetn)
    (rd_level && (addr_sync_q < `REG_ALIGN_CAPTURE || addr_sync_q > `REG_NONALIGN_CAPTURE))
      |=> (rd_data_q == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // R17

  c_align_read:  cover property (@(posedge clk) disable iff (!resetn)
                   align_strobe ##[1:20] (rd_level && addr_sync_q == `REG_ALIGN_CAPTURE));
  c_los_set:     cover property (@(posedge clk) disable iff (!resetn) $rose(los_flag_q));
  c_fifo_full:   cover property (@(posedge clk) disable iff (!resetn) jitter_q[`JIT_FULL_BIT]);
  c_bad_addr:    cover property (@(posedge clk) disable iff (!resetn)
                   rd_level && addr_sync_q == 5'h1f);
endmodule

// >>> dv/host_reader.sv
// host model that reads the e1 receive status registers over the async pins
// assumes the device synchronises its pins through two flops on clk
`timescale 1ns/1ns
module host_reader (
  input  wire logic       clk,        // device clock
  input  wire logic       rd_valid_q, // device read valid
  output logic [4:0]      reg_addr,   // address pins
  output logic            rd_n,       // read strobe, active low
  output logic            cs_n        // chip select, active low
);
  initial begin
    reg_addr = 5'h00;
    rd_n     = 1'b1;
    cs_n     = 1'b1;
  end
  // ---------------------------------------------
  // read cycle
  // ---------------------------------------------
  // address settles three clocks early, the pins are sampled asynchronously
  task automatic read(input logic [4:0] addr, output bit ok);
    int n;
    ok = 1'b0;
    @(negedge clk);
    reg_addr = addr;
    repeat (3) @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge clk);
      if (rd_valid_q === 1'b1) ok = 1'b1;
    end
    @(negedge clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    // a released address does not keep its last value
    reg_addr = ~addr;
    repeat (5) @(negedge clk);
  endtask
endmodule

// >>> dv/tb_e1_receive_overhead_status.sv
// self-checking bench for the e1 receive status group
// assumes host_reader drives the register pins; loss time cut to 20 clocks
`timescale 1ns/1ns
`include "e1_status_map.svh"
module tb_e1_receive_overhead_status
  import e1_status_pkg::*;
;
  localparam int    LOS_N = 20;
  logic             clk = 1'b0;
  logic             resetn;
  logic             align_strobe;
  logic             nonalign_strobe;
  logic             below_threshold;
  logic             rd_n;
  logic             cs_n;
  logic             rd_valid_q;
  rx_word_t         ts0_word;
  peak_level_code_t peak_level_code;
  dejitter_rate_t   dejitter_rate;
  logic [5:0]       fifo_fill;
  logic [4:0]       reg_addr;
  logic [7:0]       rd_data_q;
  logic [7:0]       exp_q[$];
  logic [7:0]       al_w;
  logic [7:0]       na_w;
  int               fills[9] = '{0, 3, 4, 15, 16, 27, 28, 31, 32};
  int               fails = 0;
  int               num_checks = 0;
  int               seed = 91;
  bit               prev_valid = 1'b0;
  bit               ok;

  always #4 clk = ~clk;

  e1_receive_overhead_status #(.FIFO_DEPTH(32), .AW(6), .LOS_CYCLES(LOS_N))
    u_e1_receive_overhead_status (
    .clk(clk), .resetn(resetn), .align_strobe(align_strobe),
    .nonalign_strobe(nonalign_strobe), .ts0_word(ts0_word),
    .peak_level_code(peak_level_code), .below_threshold(below_threshold),
    .dejitter_rate(dejitter_rate), .fifo_fill(fifo_fill), .reg_addr(reg_addr),
    .rd_n(rd_n), .cs_n(cs_n), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

  host_reader u_host_reader (.clk(clk), .rd_valid_q(rd_valid_q), .reg_addr(reg_addr),
    .rd_n(rd_n), .cs_n(cs_n));

  // ---------------------------------------------
  // checking
  // ---------------------------------------------
  // first cycle of valid carries the answer; later cycles only repeat it
  always @(posedge clk) begin
    if (rd_valid_q === 1'b1 && !prev_valid) begin
      num_checks++;
      if (exp_q.size() == 0 || rd_data_q !== exp_q[0]) begin
        fails++;
        $display("ERROR %0t read data %h unexpected", $time, rd_data_q);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    prev_valid = (rd_valid_q === 1'b1);
  end

  task automatic finish_test;
    if (exp_q.size() != 0) fails++;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    u_host_reader.read(a, ok);
    if (!ok) begin
      fails++;
      $display("ERROR %0t no read answer", $time);
      finish_test();
    end
  endtask

  task automatic strobe(input bit na, input logic [7:0] w);
    @(negedge clk);
    ts0_word = w;
    align_strobe = !na;
    nonalign_strobe = na;
    @(negedge clk);
    align_strobe = 1'b0;
    nonalign_strobe = 1'b0;
    ts0_word = ~w;
  endtask

  function automatic logic [7:0] jit(input int f, input dejitter_rate_t r);
    return {r == rate_slow, r == rate_fast, f == 0, f >= 4, f >= 16, f >= 28, f == 32, 1'b0};
  endfunction

  // ---------------------------------------------
  // stimulus
  // ---------------------------------------------
  initial begin
    resetn = 1'b0;
    align_strobe = 1'b0;
    nonalign_strobe = 1'b0;
    ts0_word = 8'h00;
    peak_level_code = lvl_under4;
    below_threshold = 1'b0;
    dejitter_rate = rate_normal;
    fifo_fill = 6'h00;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      al_w = $random(seed);
      na_w = $random(seed);
      na_w[5] = i[0];
      strobe(1'b0, ~al_w);
      strobe(1'b0, al_w);
      strobe(1'b1, na_w);
      rd(`REG_ALIGN_CAPTURE, al_w);
      rd(`REG_NONALIGN_CAPTURE, na_w);
    end
    strobe(1'b0, {al_w[7], 7'h1b});
    rd(`REG_ALIGN_CAPTURE, {al_w[7], 7'h1b});
    rd(`REG_NONALIGN_CAPTURE, na_w);
    for (int i = 0; i < 5; i++) begin
      peak_level_code = peak_level_code_t'(5'h01 << i);
      rd(`REG_LINE_LEVEL, {5'h01 << i, 3'b000});
    end
    // a dip shorter than the loss time must not raise the flag
    below_threshold = 1'b1;
    repeat (10) @(negedge clk);
    below_threshold = 1'b0;
    rd(`REG_LINE_LEVEL, 8'h80);
    below_threshold = 1'b1;
    rd(`REG_LINE_LEVEL, 8'h80);
    repeat (LOS_N) @(negedge clk);
    rd(`REG_LINE_LEVEL, 8'h84);
    below_threshold = 1'b0;
    rd(`REG_LINE_LEVEL, 8'h80);
    foreach (fills[i]) begin
      fifo_fill = fills[i][5:0];
      dejitter_rate = dejitter_rate_t'(i % 3);
      rd(`REG_JITTER_STATUS, jit(fills[i], dejitter_rate));
    end
    // a second reset must clear the captures before the next read
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    rd(`REG_ALIGN_CAPTURE, `CAPTURE_RESET);
    rd(5'h00, 8'h00);
    rd(5'h19, 8'h00);
    rd(5'h1f, 8'h00);
    finish_test();
  end
endmodule
